// ---- include/led_seq_defs.svh ----
// Timing counts and field layout for the LED driver start-up sequencer
`ifndef LED_SEQ_DEFS_SVH
`define LED_SEQ_DEFS_SVH

`define CLK_PERIOD_NS 50
`define LOW_SHUTDOWN_SW_CYCLES 32750
`define DETECT_MIN_SW_CYCLES 3000
`define DETECT_MAX_SW_CYCLES 4000
`define SYNC_LOSS_NS 5000
`define SYNC_LOSS_CYC (`SYNC_LOSS_NS / `CLK_PERIOD_NS)
`define SYNC_STUCK_NS 10000
`define SYNC_STUCK_CYC (`SYNC_STUCK_NS / `CLK_PERIOD_NS)
`define SS_TIME_SW_CYCLES 8192
`define NUM_SINKS 4
`define CLASS_SHORT 2'h0
`define CLASS_UNUSED 2'h1
`define CLASS_USED 2'h2

`endif

// ---- include/led_seq_pkg.sv ----
// Types for the LED driver start-up sequencer
package led_seq_pkg;
  typedef enum logic [2:0] {
    ST_LOCKOUT,
    ST_GATE_EN,
    ST_LED_DETECT,
    ST_UV_CHECK,
    ST_SOFT_START,
    ST_REGULATE,
    ST_OC_LATCHED
  } seq_state_t;
endpackage : led_seq_pkg

// ---- logic/pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and edge pulses
module pin_sync (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic ce_i, // Clock enable
  input wire logic pin_i, // Asynchronous pin
  output logic level_o, // Filtered level
  output logic rise_o, // One-cycle rise pulse
  output logic fall_o // One-cycle fall pulse
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic lvl_r;
  logic lvl_nxt;

  always_comb begin
    sh_nxt = ce_i ? {sh_r[1:0], pin_i} : sh_r;
    lvl_nxt = lvl_r;
    // Stage 0 feeds only stage 1; stages 1 and 2 must agree
    if (ce_i && (sh_r[1] == sh_r[2])) begin
      lvl_nxt = sh_r[2];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sh_r <= 3'h0;
      lvl_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_o = lvl_r;
  assign rise_o = ce_i & lvl_nxt & ~lvl_r;
  assign fall_o = ce_i & ~lvl_nxt & lvl_r;
endmodule : pin_sync

// ---- logic/led_startup_seq.sv ----
// Start-up and fault sequencer for a four-string boost LED driver
//
// Overview of operation
// - Leave lockout only on a switch clock with enable held high since its rise and supply good.
// - Frequency-set pin held low at power-up blocks power-up entirely.
// - Enable low for 32750 switch cycles returns device to low power.
// - Supply lockout assertion always forces low-power mode.
// - Gate drive first; LED detect starts once gate reports on.
// - Sinks above 120 mV, then wait 3000 to 4000 cycles before classifying.
// - Classify sinks: short below 70 mV, unused near 150, in use near 325.
// - Unused sinks removed from regulation for the rest of the enable.
// - Any shorted sink holds soft-start; re-check that sink after release.
// - Output below undervoltage threshold after gate enable withholds soft-start.
// - Undervoltage fault shuts down unlatched and retries when it clears.
// - Input overcurrent latches off; cleared by long enable low then high.
// - Soft-start raises output along a fixed ramp, independent of dimming.
// - Soft-start ends on regulation, 93 percent of limit, or timeout.
// - Frequency-set pin shorted low in operation shuts the device down.
// - Start attempted only with pin floated to 1 V or sync detected.
// - Sync lost to open pin: internal oscillator after 5 us, no fault.
// - Sync stuck low: fault after 10 us, stop switching, restart on release.
`include "led_seq_defs.svh"

module led_startup_seq #(
  parameter int NUM_SINKS = `NUM_SINKS,
  parameter int LOW_SHUTDOWN_CYC = `LOW_SHUTDOWN_SW_CYCLES,
  parameter int DETECT_CYC = `DETECT_MIN_SW_CYCLES,
  parameter int SS_TIME_CYC = `SS_TIME_SW_CYCLES,
  parameter int SYNC_LOSS_CYC = `SYNC_LOSS_CYC,
  parameter int SYNC_STUCK_CYC = `SYNC_STUCK_CYC
) (
  input wire logic sys_clk_i, // 20 MHz system clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic ce_i, // Clock enable, freezes state when low
  input wire logic enable_pwm_i, // Dimming/enable pin (async)
  input wire logic sw_clk_tick_i, // Switching clock tick, one cycle
  input wire logic supply_ok_i, // Lockout cleared (supply above rising threshold)
  input wire logic supply_low_i, // Supply below falling threshold
  input wire logic freq_set_float_i, // Frequency-set pin floated to about 1 V
  input wire logic freq_set_sync_i, // Frequency-set pin sync clock (async)
  input wire logic gate_on_i, // Gate reached supply minus 3.3 V
  input wire logic [NUM_SINKS-1:0] sink_above_120_i, // Sink above 120 mV
  input wire logic [NUM_SINKS-1:0] sink_below_70_i, // Sink below 70 mV
  input wire logic [NUM_SINKS-1:0] sink_in_use_i, // Sink near 325 mV
  input wire logic out_above_uv_i, // Output sense above undervoltage threshold
  input wire logic input_oc_trip_i, // Input overcurrent trip
  input wire logic leds_in_reg_i, // All active LED currents regulated
  input wire logic out_at_93_i, // Output at 93 percent of overvoltage limit
  output logic gate_en_o, // Disconnect switch gate drive
  output logic switching_en_o, // Boost switching allowed
  output logic soft_start_o, // Soft-start ramp active
  output logic [15:0] ramp_o, // Fixed ramp reference level
  output logic [NUM_SINKS-1:0] sink_active_o, // Sinks in regulation loop
  output logic use_ext_sync_o, // Following external sync
  output logic fault_o, // Fault flag, high when asserted
  output logic low_power_o // In low-power mode
);
  initial begin
    if (NUM_SINKS < 1 || NUM_SINKS > 16 || LOW_SHUTDOWN_CYC < 2 || LOW_SHUTDOWN_CYC > 65535 || DETECT_CYC < 1 ||
        DETECT_CYC > `DETECT_MAX_SW_CYCLES || SS_TIME_CYC < 1 || SS_TIME_CYC > 65535 || SYNC_LOSS_CYC < 1 ||
        SYNC_STUCK_CYC <= SYNC_LOSS_CYC || SYNC_STUCK_CYC > 65534) begin
      $error("led_startup_seq: unsupported parameter values");
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic en_lvl, en_rise;
  logic sync_lvl, sync_rise;

  pin_sync u_en_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(enable_pwm_i),
    .level_o(en_lvl),
    .rise_o(en_rise),
    .fall_o()
  );

  pin_sync u_sync_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(freq_set_sync_i),
    .level_o(sync_lvl),
    .rise_o(sync_rise),
    .fall_o()
  );

  // ****************************************
  // Sync monitor
  // ****************************************
  // Counts system cycles since last sync rise; the float input tells open from short
  logic [15:0] sync_age_r, sync_age_nxt;
  logic ext_sync_r, ext_sync_nxt;
  logic fs_short_r, fs_short_nxt;

  always_comb begin
    sync_age_nxt = sync_age_r;
    ext_sync_nxt = ext_sync_r;
    fs_short_nxt = fs_short_r;
    if (sync_rise) begin
      sync_age_nxt = 16'h0;
      ext_sync_nxt = 1'b1;
      fs_short_nxt = 1'b0;
    end else begin
      if (freq_set_float_i && !ext_sync_r) begin
        sync_age_nxt = 16'h0;
      end else if (sync_age_r != 16'hffff) begin
        sync_age_nxt = sync_age_r + 16'h1;
      end
      if (sync_age_r >= 16'(SYNC_LOSS_CYC)) begin
        ext_sync_nxt = 1'b0;
      end
      // Pin low and not floating for too long counts as a short
      if (!sync_lvl && !freq_set_float_i && sync_age_r >= 16'(SYNC_STUCK_CYC)) begin
        fs_short_nxt = 1'b1;
      end else if (freq_set_float_i) begin
        fs_short_nxt = 1'b0;
      end
    end
    if (!ce_i) begin
      sync_age_nxt = sync_age_r;
      ext_sync_nxt = ext_sync_r;
      fs_short_nxt = fs_short_r;
    end
  end

  // ****************************************
  // Main sequencer
  // ****************************************
  led_seq_pkg::seq_state_t state_r, state_nxt;
  logic [15:0] low_cnt_r, low_cnt_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [NUM_SINKS-1:0] active_r, active_nxt;
  logic [NUM_SINKS-1:0] shorted_r, shorted_nxt;
  logic first_tick_r, first_tick_nxt;
  logic low_power_r, low_power_nxt;
  logic fault_r, fault_nxt;
  logic [15:0] ramp_r, ramp_nxt;
  logic fs_ok, long_low;
  logic [NUM_SINKS-1:0] cls_short, cls_unused;

  assign fs_ok = freq_set_float_i | ext_sync_r;
  assign long_low = (low_cnt_r >= 16'(LOW_SHUTDOWN_CYC));

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SINKS; gi++) begin : g_cls
      assign cls_short[gi] = sink_below_70_i[gi];
      assign cls_unused[gi] = ~sink_below_70_i[gi] & ~sink_in_use_i[gi];
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    low_cnt_nxt = low_cnt_r;
    tmr_nxt = tmr_r;
    active_nxt = active_r;
    shorted_nxt = shorted_r;
    first_tick_nxt = first_tick_r;
    low_power_nxt = low_power_r;
    fault_nxt = fs_short_r;
    ramp_nxt = ramp_r;
    // Low-time counter in switching cycles, restarts on any high
    if (en_lvl) begin
      low_cnt_nxt = 16'h0;
    end else if (sw_clk_tick_i && !long_low) begin
      low_cnt_nxt = low_cnt_r + 16'h1;
    end
    if (en_rise) begin
      first_tick_nxt = 1'b1;
    end else if (!en_lvl) begin
      first_tick_nxt = 1'b0;
    end
    unique case (state_r)
      led_seq_pkg::ST_LOCKOUT: begin
        low_power_nxt = 1'b1;
        active_nxt = '1;
        shorted_nxt = '0;
        ramp_nxt = 16'h0;
        // Enable must have stayed high since its rise; any switching tick after that can leave lockout
        if (sw_clk_tick_i && first_tick_r && en_lvl && supply_ok_i && fs_ok) begin
          state_nxt = led_seq_pkg::ST_GATE_EN;
          low_power_nxt = 1'b0;
        end
      end
      led_seq_pkg::ST_GATE_EN: begin
        tmr_nxt = 16'h0;
        if (gate_on_i) begin
          state_nxt = led_seq_pkg::ST_LED_DETECT;
        end
      end
      led_seq_pkg::ST_LED_DETECT: begin
        if (!(&(sink_above_120_i | shorted_r | sink_below_70_i))) begin
          tmr_nxt = 16'h0;
        end else if (sw_clk_tick_i) begin
          tmr_nxt = tmr_r + 16'h1;
        end
        if (tmr_r >= 16'(DETECT_CYC)) begin
          shorted_nxt = cls_short;
          // Shorted sinks stay listed so the re-check after release keeps them
          active_nxt = active_r & ~cls_unused;
          tmr_nxt = 16'h0;
          if (cls_short == '0) begin
            state_nxt = led_seq_pkg::ST_UV_CHECK;
          end else begin
            state_nxt = led_seq_pkg::ST_LED_DETECT;
          end
        end
      end
      led_seq_pkg::ST_UV_CHECK: begin
        if (out_above_uv_i) begin
          state_nxt = led_seq_pkg::ST_SOFT_START;
          tmr_nxt = 16'h0;
          ramp_nxt = 16'h0;
        end
      end
      led_seq_pkg::ST_SOFT_START: begin
        if (sw_clk_tick_i) begin
          tmr_nxt = tmr_r + 16'h1;
          ramp_nxt = ramp_r + 16'h1;
        end
        if (leds_in_reg_i || out_at_93_i || tmr_r >= 16'(SS_TIME_CYC)) begin
          state_nxt = led_seq_pkg::ST_REGULATE;
        end
      end
      led_seq_pkg::ST_REGULATE: begin
      end
      led_seq_pkg::ST_OC_LATCHED: begin
        fault_nxt = 1'b1;
        if (long_low) begin
          low_power_nxt = 1'b1;
        end
        if (long_low && en_rise) begin
          state_nxt = led_seq_pkg::ST_LOCKOUT;
          first_tick_nxt = 1'b1;
        end
      end
    endcase
    // Faults, highest priority last
    if (state_r != led_seq_pkg::ST_LOCKOUT && state_r != led_seq_pkg::ST_OC_LATCHED) begin
      if ((state_r == led_seq_pkg::ST_SOFT_START || state_r == led_seq_pkg::ST_REGULATE) &&
          !out_above_uv_i) begin
        state_nxt = led_seq_pkg::ST_UV_CHECK;
      end
      if (fs_short_r) begin
        state_nxt = led_seq_pkg::ST_UV_CHECK;
        if (state_r != led_seq_pkg::ST_GATE_EN && state_r != led_seq_pkg::ST_LED_DETECT) begin
          ramp_nxt = 16'h0;
        end
      end
      if (long_low) begin
        state_nxt = led_seq_pkg::ST_LOCKOUT;
      end
      if (input_oc_trip_i) begin
        state_nxt = led_seq_pkg::ST_OC_LATCHED;
      end
    end
    if (supply_low_i) begin
      state_nxt = led_seq_pkg::ST_LOCKOUT;
      low_power_nxt = 1'b1;
    end
    if (!ce_i) begin
      state_nxt = state_r;
      low_cnt_nxt = low_cnt_r;
      tmr_nxt = tmr_r;
      active_nxt = active_r;
      shorted_nxt = shorted_r;
      first_tick_nxt = first_tick_r;
      low_power_nxt = low_power_r;
      fault_nxt = fault_r;
      ramp_nxt = ramp_r;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  logic gate_r, sw_r, ss_r, ext_out_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= led_seq_pkg::ST_LOCKOUT;
      low_cnt_r <= 16'h0;
      tmr_r <= 16'h0;
      active_r <= '0;
      shorted_r <= '0;
      first_tick_r <= 1'b0;
      low_power_r <= 1'b1;
      fault_r <= 1'b0;
      ramp_r <= 16'h0;
      sync_age_r <= 16'hffff;
      ext_sync_r <= 1'b0;
      fs_short_r <= 1'b0;
      gate_r <= 1'b0;
      sw_r <= 1'b0;
      ss_r <= 1'b0;
      ext_out_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      low_cnt_r <= low_cnt_nxt;
      tmr_r <= tmr_nxt;
      active_r <= active_nxt;
      shorted_r <= shorted_nxt;
      first_tick_r <= first_tick_nxt;
      low_power_r <= low_power_nxt;
      fault_r <= fault_nxt;
      ramp_r <= ramp_nxt;
      sync_age_r <= sync_age_nxt;
      ext_sync_r <= ext_sync_nxt;
      fs_short_r <= fs_short_nxt;
      if (ce_i) begin
        gate_r <= (state_nxt != led_seq_pkg::ST_LOCKOUT) && (state_nxt != led_seq_pkg::ST_OC_LATCHED);
        sw_r <= (state_nxt == led_seq_pkg::ST_SOFT_START || state_nxt == led_seq_pkg::ST_REGULATE) &&
                !fs_short_nxt && en_lvl;
        ss_r <= (state_nxt == led_seq_pkg::ST_SOFT_START);
        ext_out_r <= ext_sync_nxt;
      end
    end
  end

  assign gate_en_o = gate_r;
  assign switching_en_o = sw_r;
  assign soft_start_o = ss_r;
  assign ramp_o = ramp_r;
  assign sink_active_o = active_r;
  assign use_ext_sync_o = ext_out_r;
  assign fault_o = fault_r;
  assign low_power_o = low_power_r;
endmodule : led_startup_seq

// ---- bench/host_model.sv ----
// Host model: enable pin and sync clock source
module host_model (
  input wire logic en_req_i, // Wanted enable level
  input wire logic sync_run_i, // Sync clock wanted
  output logic enable_o, // Enable/dimming pin
  output logic sync_o // Sync clock, parked low when stopped
);
  timeunit 1ns;
  timeprecision 1ns;
  // Long lows from the bench clear a latched trip
  assign enable_o = en_req_i;
  // 200 ns high and low keeps duty at 50 percent, inside every window
  initial begin
    sync_o = 1'b0;
    forever begin
      #200;
      sync_o = sync_run_i ? ~sync_o : 1'b0;
    end
  end
endmodule : host_model

// ---- bench/led_seq_properties.sv ----
// Port checker for the LED start-up sequencer
module led_seq_properties #(
  parameter int NUM_SINKS = 4
) (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic supply_ok_i, // Supply good
  input wire logic supply_low_i, // Supply fell
  input wire logic freq_set_float_i, // Pin floated
  input wire logic [NUM_SINKS-1:0] sink_below_70_i, // Shorted sinks
  input wire logic out_above_uv_i, // Output good
  input wire logic out_at_93_i, // Output near limit
  input wire logic gate_en_o, // Gate drive
  input wire logic switching_en_o, // Switching
  input wire logic soft_start_o, // Soft-start
  input wire logic use_ext_sync_o, // External sync
  input wire logic fault_o, // Fault
  input wire logic low_power_o // Low power
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ****************************
  // Start-up order and faults
  // ****************************
  gate_cause_a: assert property ($rose(gate_en_o) |-> $past(supply_ok_i))
    else $error("gate on without supply");
  freq_set_pin_block_a: assert property (low_power_o && !freq_set_float_i && !use_ext_sync_o |=> low_power_o)
    else $error("left low power with pin low");
  uv_gate_a: assert property ($rose(soft_start_o) |-> $past(out_above_uv_i))
    else $error("soft-start with output low");
  short_hold_a: assert property ($rose(soft_start_o) |-> $past(sink_below_70_i) == '0)
    else $error("soft-start with shorted sink");
  ss_end_a: assert property (soft_start_o && out_at_93_i |-> ##[1:2] !soft_start_o)
    else $error("soft-start did not end");
  uv_stop_a: assert property (switching_en_o && !out_above_uv_i |-> ##[1:2] !switching_en_o)
    else $error("switching kept on output low");
  supply_drop_a: assert property (supply_low_i |-> ##[1:3] low_power_o)
    else $error("no low power on supply drop");
  fault_stop_a: assert property (fault_o [*2] |-> !switching_en_o)
    else $error("switching during fault");
  cover property ($rose(use_ext_sync_o));
  cover property ($fell(soft_start_o));
  cover property ($rose(fault_o));
endmodule : led_seq_properties

bind led_startup_seq led_seq_properties #(.NUM_SINKS(NUM_SINKS)) u_led_seq_properties (
  .sys_clk_i, .rst_i, .supply_ok_i, .supply_low_i, .freq_set_float_i, .sink_below_70_i,
  .out_above_uv_i, .out_at_93_i, .gate_en_o, .switching_en_o, .soft_start_o,
  .use_ext_sync_o, .fault_o, .low_power_o);

// ---- bench/led_driver_startup_fault_sequencer_tb.sv ----
// Testbench for the LED start-up sequencer
module led_driver_startup_fault_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error %s exp %0h got %0h", n, e, a); end end
  `define WT(c) begin k = 0; while (!(c) && k < 600) begin @(posedge clk); k++; end \
    if (!(c)) begin n_mismatch++; $display("Error wait_limit exp %0d got %0d", 600, k); end end
  logic clk, rst = 1'b1, ce = 1'b1, tick = 1'b0, en_req = 1'b0, sync_run = 1'b0, en_pin, sync_pin;
  logic ok = 1'b1, low = 1'b0, flt = 1'b1, gon = 1'b0, uv = 1'b1, oc = 1'b0, inreg = 1'b0, at93 = 1'b0;
  logic [3:0] s120 = 4'hf, s70 = 4'h0, suse = 4'hb, act;
  logic gate, sw, ss, ext, fault, lp;
  logic [15:0] ramp, r0;
  int cmp_count, n_mismatch, k, cyc;
  host_model u_host_model (.en_req_i(en_req), .sync_run_i(sync_run), .enable_o(en_pin), .sync_o(sync_pin));
  // Short counts keep the run brief: low time 20, detect 5, soft-start 10 ticks
  led_startup_seq #(.LOW_SHUTDOWN_CYC(20), .DETECT_CYC(5), .SS_TIME_CYC(10)) u_led_startup_seq (
    .sys_clk_i(clk), .rst_i(rst), .ce_i(ce), .enable_pwm_i(en_pin), .sw_clk_tick_i(tick),
    .supply_ok_i(ok), .supply_low_i(low), .freq_set_float_i(flt), .freq_set_sync_i(sync_pin),
    .gate_on_i(gon), .sink_above_120_i(s120), .sink_below_70_i(s70), .sink_in_use_i(suse),
    .out_above_uv_i(uv), .input_oc_trip_i(oc), .leds_in_reg_i(inreg), .out_at_93_i(at93),
    .gate_en_o(gate), .switching_en_o(sw), .soft_start_o(ss), .ramp_o(ramp), .sink_active_o(act),
    .use_ext_sync_o(ext), .fault_o(fault), .low_power_o(lp));
  // ****************************
  // Clock, tick and watchdog
  // ****************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    tick <= ~tick;
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // Long low then rise: leaves any latch and restarts
  task automatic restart();
    en_req <= 1'b0;
    repeat (60) @(posedge clk);
    en_req <= 1'b1;
    `WT(ss)
  endtask : restart
  task automatic t_block();
    flt <= 1'b0;
    en_req <= 1'b1;
    repeat (60) @(posedge clk);
    `CHK("low_power", 1'b1, lp)
    flt <= 1'b1;
    `WT(gate)
    `CHK("low_power", 1'b0, lp)
    repeat (30) @(posedge clk);
    `CHK("soft_start", 1'b0, ss)
    gon <= 1'b1;
  endtask : t_block
  task automatic t_run();
    `WT(ss)
    `CHK("soft_start", 1'b1, ss)
    `CHK("detect_time", 1'b1, k >= 11 && k <= 17)
    r0 = ramp;
    repeat (6) @(posedge clk);
    `CHK("ramp_up", 1'b1, ramp > r0)
    inreg <= 1'b1;
    `WT(!ss)
    `CHK("sinks", 4'hb, act)
    inreg <= 1'b0;
    uv <= 1'b0;
    `WT(!sw)
    `CHK("switching", 1'b0, sw)
    uv <= 1'b1;
    `WT(ss)
    at93 <= 1'b1;
    `WT(!ss)
    `CHK("ss_by_93", 1'b0, ss)
    at93 <= 1'b0;
    uv <= 1'b0;
    repeat (4) @(posedge clk);
    uv <= 1'b1;
    `WT(ss)
    `WT(!ss)
    `CHK("ss_time", 1'b1, k >= 16 && k <= 26)
    `CHK("sinks", 4'hb, act)
  endtask : t_run
  task automatic t_low();
    en_req <= 1'b0;
    repeat (30) @(posedge clk);
    en_req <= 1'b1;
    repeat (8) @(posedge clk);
    en_req <= 1'b0;
    repeat (30) @(posedge clk);
    `CHK("low_power", 1'b0, lp)
    ce <= 1'b0;
    repeat (60) @(posedge clk);
    `CHK("low_power", 1'b0, lp)
    ce <= 1'b1;
    `WT(lp)
    `CHK("low_power", 1'b1, lp)
    s70 <= 4'h1;
    suse <= 4'ha;
    en_req <= 1'b1;
    repeat (80) @(posedge clk);
    `CHK("soft_start", 1'b0, ss)
    s70 <= 4'h0;
    suse <= 4'hb;
    `WT(ss)
    `CHK("soft_start", 1'b1, ss)
    `CHK("sinks", 4'hb, act)
  endtask : t_low
  task automatic t_fault();
    ok <= 1'b0;
    low <= 1'b1;
    `WT(lp)
    `CHK("low_power", 1'b1, lp)
    low <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK("low_power", 1'b1, lp)
    ok <= 1'b1;
    restart();
    oc <= 1'b1;
    `WT(fault)
    oc <= 1'b0;
    en_req <= 1'b0;
    repeat (10) @(posedge clk);
    en_req <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK("fault", 1'b1, fault)
    `CHK("switching", 1'b0, sw)
    restart();
    `CHK("soft_start", 1'b1, ss)
  endtask : t_fault
  task automatic t_sync();
    flt <= 1'b0;
    sync_run <= 1'b1;
    restart();
    `CHK("ext_sync", 1'b1, ext)
    sync_run <= 1'b0;
    flt <= 1'b1;
    `WT(!ext)
    `CHK("ext_sync", 1'b0, ext)
    `CHK("loss_time", 1'b1, k >= 90 && k <= 115)
    `CHK("fault", 1'b0, fault)
    flt <= 1'b0;
    sync_run <= 1'b1;
    `WT(ext)
    sync_run <= 1'b0;
    `WT(fault)
    `CHK("fault", 1'b1, fault)
    `CHK("stuck_time", 1'b1, k >= 185 && k <= 215)
    `CHK("switching", 1'b0, sw)
    flt <= 1'b1;
    `WT(ss)
    `CHK("soft_start", 1'b1, ss)
  endtask : t_sync
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_block();
    t_run();
    t_low();
    t_fault();
    t_sync();
    print_verdict();
  end
endmodule : led_driver_startup_fault_sequencer_tb
